// [rtl/utxro_pkg.sv]
// constants shared by the serial block and its routing logic
package utxro_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] OFS_ROUT [8] = '{8'h22, 8'h26, 8'h2A, 8'h2E,
                                          8'h32, 8'h36, 8'h3A, 8'h3E};
  localparam logic [7:0] OFS_FUNC = 8'h30;
  localparam logic [7:0] OFS_TXDATA = 8'h31;
  localparam logic [7:0] OFS_RXDATA = 8'h33;
  localparam logic [7:0] OFS_CTRL = 8'h35;
  // function register fields
  localparam int FN_MODE1 = 4;
  localparam int FN_MODE0 = 3;
  localparam logic [2:0] FN_UART = 3'h5;
  // output routing fields
  localparam int RT_AUX_EN = 5;
  localparam int RT_AUX_HI = 4;
  localparam int RT_AUX_LO = 3;
  localparam int RT_OUT_EN = 2;
  // control/status fields
  localparam int CS_ENABLE = 0;
  localparam int CS_PAR_EN = 1;
  localparam int CS_PAR_ODD = 2;
  localparam int CS_EMPTY_FULL = 3;
  localparam int CS_DONE_PERR = 4;
  localparam int CS_FRAME = 5;
  localparam int CS_OVERRUN = 6;
  localparam int CS_IRQ_EN = 7;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // last baud tick index of a bit (eight ticks per bit) and the start-bit midpoint
  localparam logic [2:0] TICKS_LAST = 3'h7;
  localparam logic [2:0] TICKS_MID = 3'h3;
endpackage : utxro_pkg

// [rtl/utxro_sync.sv]
// three-stage synchroniser with debounced level and rising-edge pulse
`timescale 1ns/1ps
module utxro_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic async_in,
  output logic level,
  output logic rise
);
  logic ff1_reg, ff2_reg, ff3_reg, lvl_reg;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ff1_reg <= INIT;
      ff2_reg <= INIT;
      ff3_reg <= INIT;
    end else begin
      ff1_reg <= async_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end
  // accept a change only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lvl_reg <= INIT;
    end else if (ff2_reg == ff3_reg) begin
      lvl_reg <= ff3_reg;
    end
  end
  assign level = lvl_reg;
  assign rise = (ff2_reg == ff3_reg) && ff3_reg && !lvl_reg;
endmodule : utxro_sync

// [rtl/utxro_top.sv]
// serial transmitter/receiver block with global output routing
// What this block does
// [RULE_01] aux select picks global line per block
// [RULE_02] out enable gates primary output
// [RULE_03] out select picks global output line
// [RULE_04] primary output feeds next block clock
// [RULE_05] receiver runs on eight-times baud clock
// [RULE_06] receive interrupt on holding full
// [RULE_07] status read clears all but full
// [RULE_08] data read clears receive full
// [RULE_09] software must read received byte
// [RULE_10] missing stop flags framing error
// [RULE_11] eight data bits with start, stop
// [RULE_12] empty shifter loads waiting held byte
// [RULE_13] holding register gives one-byte buffer
// [RULE_14] control holds parity, shows completion
// [RULE_15] transmitter runs on eight-times baud clock
// [RULE_16] transmit ignores data input
// [RULE_17] serial stream on primary output
// [RULE_18] interrupt on empty or complete
// [RULE_19] complete only after stop bit leaves
// [RULE_20] software primes holding register first
// [RULE_21] status read keeps holding empty flag
// [RULE_22] interrupt does not clear status
// [RULE_23] idle line held high
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module utxro_top
  import utxro_pkg::*;
#(
  parameter int BLK_NUM = 4
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic baud_clk_in,
  input wire logic rx_data_in,
  input wire logic [7:0] blk_prim_in,
  input wire logic [7:0] blk_aux_in,
  input wire logic [7:0] glob_in,
  output logic [7:0] glob_out,
  output logic [7:0] aux_in_sel,
  output logic next_blk_clk,
  output logic block_irq
);
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PAR = 3'b011, TX_STOP = 3'b100
  } utxro_tx_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PAR = 3'b011, RX_STOP = 3'b100
  } utxro_rx_t;

  logic [7:0] rout_reg [8];
  logic [7:0] func_reg, ctrl_reg, hold_reg, shift_reg, rxbuf_reg, rxsh_reg;
  logic [31:0] prdata_reg;
  logic hold_full_reg, st_empty_reg, st_done_reg, tx_line_reg;
  logic rx_full_reg, st_perr_reg, st_frame_reg, st_ovr_reg;
  logic [2:0] tx_tick_reg, tx_bit_reg, rx_tick_reg, rx_bit_reg;
  utxro_tx_t tx_state;
  utxro_rx_t rx_state;
  logic baud_tick, rx_line, prim_out, run, tx_mode, par_bit;
  logic wr_acc, rd_acc, hit, tx_wr, rx_rd, cs_rd, tx_load, tx_done, rx_done;
  logic tx_bit_end, rx_smp, rx_perr_now;

  function automatic logic [5:0] idx_of(input logic [7:0] ofs);
    return ofs[5:0];
  endfunction : idx_of

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    return (a[1:0] == 2'h0) && (a[7:2] == idx_of(ofs));
  endfunction : is_reg

  // [RULE_05] baud clock arrives from the input multiplexer
  utxro_sync #(.INIT(1'b0)) u_baud (
    .ref_clk(ref_clk), .nrst(nrst), .async_in(baud_clk_in),
    .level(), .rise(baud_tick)
  );
  utxro_sync #(.INIT(1'b1)) u_rxd (
    .ref_clk(ref_clk), .nrst(nrst), .async_in(rx_data_in),
    .level(rx_line), .rise()
  );

  assign run = ctrl_reg[CS_ENABLE] && (func_reg[2:0] == FN_UART);
  assign tx_mode = func_reg[FN_MODE0];

  // zero-wait slave; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  always_comb begin
    hit = is_reg(paddr, OFS_FUNC) || is_reg(paddr, OFS_TXDATA) ||
          is_reg(paddr, OFS_RXDATA) || is_reg(paddr, OFS_CTRL);
    for (int b = 0; b < 8; b++) begin
      hit = hit || is_reg(paddr, OFS_ROUT[b]);
    end
  end
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_reg;
  assign tx_wr = wr_acc && is_reg(paddr, OFS_TXDATA);
  assign rx_rd = rd_acc && is_reg(paddr, OFS_RXDATA);
  assign cs_rd = rd_acc && is_reg(paddr, OFS_CTRL);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= 32'h00000000;
      for (int b = 0; b < 8; b++) begin
        if (is_reg(paddr, OFS_ROUT[b])) prdata_reg[7:0] <= rout_reg[b];
      end
      if (is_reg(paddr, OFS_FUNC)) prdata_reg[7:0] <= func_reg;
      if (is_reg(paddr, OFS_RXDATA)) prdata_reg[7:0] <= rxbuf_reg;
      if (is_reg(paddr, OFS_CTRL)) begin
        prdata_reg[7:0] <= {ctrl_reg[CS_IRQ_EN], 
          tx_mode ? 1'b0 : st_ovr_reg, tx_mode ? 1'b0 : st_frame_reg,
          tx_mode ? st_done_reg : st_perr_reg,
          tx_mode ? st_empty_reg : rx_full_reg, ctrl_reg[2:0]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int b = 0; b < 8; b++) rout_reg[b] <= RST_BYTE;
      func_reg <= RST_BYTE;
      ctrl_reg <= RST_BYTE;
    end else if (wr_acc) begin
      for (int b = 0; b < 8; b++) begin
        if (is_reg(paddr, OFS_ROUT[b])) rout_reg[b] <= {2'h0, pwdata[5:0]};
      end
      if (is_reg(paddr, OFS_FUNC)) func_reg <= {2'h0, pwdata[5:0]};
      // [RULE_14] parity enable and type
      if (is_reg(paddr, OFS_CTRL)) begin
        ctrl_reg <= {pwdata[7], 4'h0, pwdata[2:0]};
      end
    end
  end

  // [RULE_13] one-byte holding buffer ahead of the shifter
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hold_reg <= RST_BYTE;
      hold_full_reg <= 1'b0;
    end else if (tx_wr) begin
      hold_reg <= pwdata[7:0];
      hold_full_reg <= 1'b1;
    end else if (tx_load) begin
      hold_full_reg <= 1'b0;
    end
  end

  // [RULE_12] load the shifter when it is empty; a write wins one cycle
  assign tx_load = run && tx_mode && tx_state == TX_IDLE && hold_full_reg && !tx_wr;
  assign tx_bit_end = baud_tick && tx_tick_reg == TICKS_LAST;
  assign par_bit = (^shift_reg) ^ ctrl_reg[CS_PAR_ODD];
  assign tx_done = tx_state == TX_STOP && tx_bit_end;

  // [RULE_15] eight baud ticks per transmitted bit
  always_ff @(posedge ref_clk) begin
    if (!nrst || tx_state == TX_IDLE) begin
      tx_tick_reg <= 3'h0;
    end else if (baud_tick) begin
      tx_tick_reg <= tx_tick_reg + 3'h1;
    end
  end

  // [RULE_11] start, eight data bits, optional parity, stop
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_state <= TX_IDLE;
      shift_reg <= RST_BYTE;
      tx_bit_reg <= 3'h0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            shift_reg <= hold_reg;
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_bit_reg <= 3'h0;
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end && tx_bit_reg == 3'h7) begin
            tx_state <= ctrl_reg[CS_PAR_EN] ? TX_PAR : TX_STOP;
          end else if (tx_bit_end) begin
            tx_bit_reg <= tx_bit_reg + 3'h1;
          end
        end
        TX_PAR: begin
          if (tx_bit_end) tx_state <= TX_STOP;
        end
        TX_STOP: begin
          if (tx_bit_end) tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // [RULE_23] line idles at mark; lsb first in data bits
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_line_reg <= 1'b1;
    end else begin
      case (tx_state)
        TX_START: tx_line_reg <= 1'b0;
        TX_DATA: tx_line_reg <= shift_reg[tx_bit_reg];
        TX_PAR: tx_line_reg <= par_bit;
        default: tx_line_reg <= 1'b1;
      endcase
    end
  end

  // [RULE_21] holding empty set on transfer, cleared only by a data write
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_empty_reg <= 1'b0;
    end else if (tx_load) begin
      st_empty_reg <= 1'b1;
    end else if (tx_wr) begin
      st_empty_reg <= 1'b0;
    end
  end

  // [RULE_19] complete set as the stop bit ends; a status read clears it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_done_reg <= 1'b0;
    end else if (tx_done) begin
      st_done_reg <= 1'b1;
    end else if (cs_rd && tx_mode) begin
      st_done_reg <= 1'b0;
    end
  end

  // [RULE_16] data input only observed in receive mode
  assign rx_smp = baud_tick &&
    (rx_tick_reg == (rx_state == RX_START ? TICKS_MID : TICKS_LAST));
  assign rx_done = rx_state == RX_STOP && rx_smp;
  assign rx_perr_now = rx_state == RX_PAR && rx_smp &&
    (rx_line != ((^rxsh_reg) ^ ctrl_reg[CS_PAR_ODD]));

  always_ff @(posedge ref_clk) begin
    if (!nrst || rx_state == RX_IDLE || rx_smp) begin
      rx_tick_reg <= 3'h0;
    end else if (baud_tick) begin
      rx_tick_reg <= rx_tick_reg + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_state <= RX_IDLE;
      rxsh_reg <= RST_BYTE;
      rx_bit_reg <= 3'h0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (run && !tx_mode && !rx_line) rx_state <= RX_START;
        end
        RX_START: begin
          if (rx_smp) begin
            rx_bit_reg <= 3'h0;
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_smp) begin
            rxsh_reg <= {rx_line, rxsh_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) begin
              rx_state <= ctrl_reg[CS_PAR_EN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_smp) rx_state <= RX_STOP;
        end
        RX_STOP: begin
          // [RULE_10] a low stop bit is taken as the next start bit
          if (rx_smp) begin
            rx_bit_reg <= 3'h0;
            rx_state <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // [RULE_08] full set by a new byte, cleared by reading it; set wins
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rxbuf_reg <= RST_BYTE;
      rx_full_reg <= 1'b0;
    end else if (rx_done) begin
      rxbuf_reg <= rxsh_reg;
      rx_full_reg <= 1'b1;
    end else if (rx_rd) begin
      rx_full_reg <= 1'b0;
    end
  end

  // [RULE_07] status read clears error bits, receive full untouched
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_perr_reg <= 1'b0;
      st_frame_reg <= 1'b0;
      st_ovr_reg <= 1'b0;
    end else begin
      st_perr_reg <= rx_perr_now || (st_perr_reg && !(cs_rd && !tx_mode));
      st_frame_reg <= (rx_done && !rx_line) ||
                      (st_frame_reg && !(cs_rd && !tx_mode));
      st_ovr_reg <= (rx_done && rx_full_reg && !rx_rd) ||
                    (st_ovr_reg && !(cs_rd && !tx_mode));
    end
  end

  // [RULE_18] source picked by the upper mode bit
  // [RULE_06] receive side interrupts on holding full
  // [RULE_22] status persists; only reads or writes clear it
  assign block_irq = ctrl_reg[CS_IRQ_EN] && run && (tx_mode ?
    (func_reg[FN_MODE1] ? st_done_reg : st_empty_reg) : rx_full_reg);

  // [RULE_17] transmit stream is the primary output; receive has none
  assign prim_out = run && tx_mode && tx_line_reg;
  // [RULE_04] primary output offered as the next block's clock
  assign next_blk_clk = prim_out;

  // [RULE_01] aux input choice for the upper four blocks
  // [RULE_02] out enable gates each primary
  // [RULE_03] out select steers within the block's group of four
  always_comb begin
    logic p, a;
    logic [2:0] base;
    p = 1'b0;
    a = 1'b0;
    base = 3'h0;
    glob_out = 8'h00;
    aux_in_sel = 8'h00;
    for (int b = 0; b < 8; b++) begin
      p = (b == BLK_NUM) ? prim_out : blk_prim_in[b];
      a = (b == BLK_NUM) ? 1'b0 : blk_aux_in[b];
      base = (b < 4) ? 3'h0 : 3'h4;
      if (rout_reg[b][RT_OUT_EN] && p) begin
        glob_out[base + {1'b0, rout_reg[b][1:0]}] = 1'b1;
      end
      if (rout_reg[b][RT_AUX_EN] && a) begin
        glob_out[base + {1'b0, rout_reg[b][RT_AUX_HI:RT_AUX_LO]}] = 1'b1;
      end
      if (b >= 4) begin
        aux_in_sel[b] = glob_in[base + {1'b0, rout_reg[b][RT_AUX_HI:RT_AUX_LO]}];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_idle_mark_high: assert property (tx_state == TX_IDLE |=> tx_line_reg) // [RULE_23]
    else $error("tx line not high while idle");
  a_start_bit_low: assert property (tx_state == TX_START |=> !tx_line_reg) // [RULE_11]
    else $error("start bit not low");
  a_shifter_load: assert property (tx_load |=> tx_state == TX_START && !hold_full_reg) // [RULE_12]
    else $error("held byte not moved to shifter");
  a_empty_write_clr: assert property (tx_wr |=> !st_empty_reg && hold_full_reg) // [RULE_21]
    else $error("holding empty survived a data write");
  a_empty_read_keep: assert property (cs_rd && st_empty_reg && !tx_wr |=> st_empty_reg) // [RULE_21]
    else $error("status read cleared holding empty");
  a_done_after_stop: assert property ($rose(st_done_reg) |-> $past(tx_state) == TX_STOP) // [RULE_19]
    else $error("complete set before stop bit left");
  a_rx_full_keep: assert property (cs_rd && rx_full_reg |=> rx_full_reg) // [RULE_07]
    else $error("status read cleared receive full");
  a_rx_read_clr: assert property (rx_rd && !rx_done |=> !rx_full_reg) // [RULE_08]
    else $error("data read left receive full set");
  a_frame_flag: assert property (rx_done && !rx_line |=> st_frame_reg ##0 rx_state == RX_DATA) // [RULE_10]
    else $error("missing stop bit not flagged");
  a_irq_complete: assert property (run && tx_mode && func_reg[FN_MODE1] &&
    ctrl_reg[CS_IRQ_EN] && st_done_reg |-> block_irq) // [RULE_18]
    else $error("complete interrupt missing");
  a_route_prim: assert property (rout_reg[BLK_NUM][RT_OUT_EN] && prim_out |->
    glob_out[{BLK_NUM >= 4, rout_reg[BLK_NUM][1:0]}]) // [RULE_03]
    else $error("primary output not on selected line");
  c_tx_frame: cover property (tx_done);
  c_rx_byte: cover property (rx_done && rx_line);
  c_frame_err: cover property (rx_done && !rx_line);
  c_back_to_back: cover property (tx_done ##[1:4] tx_load);
endmodule : utxro_top

// [sim/tb.sv]
// self-checking bench for the serial block and its output routing
`timescale 1ns/1ps
module tb;
  import utxro_pkg::*;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, blk_prim_in, blk_aux_in, glob_in, glob_out, aux_in_sel;
  logic [31:0] pwdata, prdata, seed;
  logic baud_clk_in, rx_data_in, next_blk_clk, block_irq, got_valid;
  logic par_en, par_odd, listen;
  logic [2:0] bcnt;
  logic [9:0] got;
  logic [64:0] note;
  logic [64:0] rd_q[$];
  logic [9:0] tx_q[$];
  int err_total, cmp_count;

  utxro_top #(.BLK_NUM(4)) i_utxro_top (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .baud_clk_in(baud_clk_in), .rx_data_in(rx_data_in),
    .blk_prim_in(blk_prim_in), .blk_aux_in(blk_aux_in), .glob_in(glob_in),
    .glob_out(glob_out), .aux_in_sel(aux_in_sel), .next_blk_clk(next_blk_clk),
    .block_irq(block_irq));
  // line held high, and so ignored, while listen is low
  utxro_remote u_remote (.ref_clk(ref_clk), .line_in(glob_out[5] | ~listen),
    .par_en(par_en), .line_out(rx_data_in), .got(got), .got_valid(got_valid));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // baud clock at one eighth of the system clock
  always @(posedge ref_clk) begin
    bcnt <= bcnt + 3'h1;
    baud_clk_in <= bcnt[2];
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task end_of_test();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  task fail(input string m);
    $display("wrong value at %0t: %s", $time, m);
    err_total++;
  endtask : fail
  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    cmp_count++;
    if (g !== e) fail(m);
  endtask : chk
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx[5:0], 2'h0};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail("no ready");
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next call never reassigns psel in this time step
    @(posedge ref_clk);
  endtask : apb
  task wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task rd(input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m, input logic er);
    rd_q.push_back({er, m, e});
    apb(1'b0, idx, 32'h0);
  endtask : rd
  task tx(input logic [7:0] b);
    tx_q.push_back({1'b1, par_en ? (par_odd ? ~^b : ^b) : 1'b0, b});
    wr(OFS_TXDATA, {24'h0, b});
  endtask : tx
  task wait_on(input logic for_irq);
    int n;
    n = 0;
    while ((for_irq ? block_irq !== 1'b1 : tx_q.size() > 0) && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 4000) begin
      fail("wait ran out");
      end_of_test();
    end
  endtask : wait_on

  // oldest note against each read answer and each received frame
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
      note = rd_q.pop_front();
      if (note[64] || note[63:32] != 32'h0) begin
        cmp_count++;
        if ({pslverr, prdata & note[63:32]} !== {note[64], note[31:0]}) fail("register read");
      end
    end
    if (got_valid === 1'b1) begin
      cmp_count++;
      if (tx_q.size() == 0 || got !== tx_q.pop_front()) fail("serial frame");
    end
  end

  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, bcnt, baud_clk_in} = '0;
    {par_en, par_odd, listen, blk_prim_in, blk_aux_in, glob_in} = '0;
    err_total = 0;
    cmp_count = 0;
    seed = 32'h5C4A;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    seed = lfsr(seed);
    blk_prim_in <= seed[7:0];
    glob_in <= seed[15:8];
    blk_aux_in <= seed[23:16];
    @(posedge ref_clk);
    rd(OFS_ROUT[4], 32'h0, 32'hFF, 1'b0);
    rd(OFS_CTRL, 32'h0, 32'hFF, 1'b0);
    rd(8'h01, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(OFS_ROUT[7], seed);
    rd(OFS_ROUT[7], {26'h0, seed[5:0]}, 32'hFF, 1'b0);
    wr(OFS_ROUT[7], 32'h0);
    rd(OFS_TXDATA, 32'h0, 32'hFF, 1'b0);
    wr(OFS_FUNC, 32'h0D);
    wr(OFS_CTRL, 32'h01);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_ROUT[4], 32'h04 | s);
      repeat (2) @(posedge ref_clk);
      chk(glob_out[7:4], 8'h01 << s, "out select");
    end
    wr(OFS_ROUT[4], 32'h01);
    repeat (2) @(posedge ref_clk);
    chk(glob_out[7:4], 8'h00, "out enable");
    wr(OFS_ROUT[0], 32'h06);
    repeat (2) @(posedge ref_clk);
    chk(glob_out[3:0], {5'h0, blk_prim_in[0], 2'h0}, "low block route");
    wr(OFS_ROUT[0], 32'h0);
    wr(OFS_ROUT[5], 32'h18);
    repeat (2) @(posedge ref_clk);
    chk(aux_in_sel[5], glob_in[7], "aux select");
    chk(next_blk_clk, 1'b1, "idle line");
    wr(OFS_ROUT[4], 32'h05);
    listen = 1'b1;
    par_en = 1'b1;
    wr(OFS_CTRL, 32'h83);
    repeat (2) @(posedge ref_clk);
    chk(block_irq, 1'b0, "irq before first byte");
    seed = lfsr(seed);
    tx(seed[7:0]);
    wait_on(1'b0);
    rd(OFS_CTRL, 32'h08, 32'h18, 1'b0);
    repeat (40) @(posedge ref_clk);
    rd(OFS_CTRL, 32'h18, 32'h18, 1'b0);
    par_odd = 1'b1;
    wr(OFS_CTRL, 32'h87);
    seed = lfsr(seed);
    tx(seed[7:0]);
    tx(seed[15:8]);
    repeat (2) @(posedge ref_clk);
    chk(block_irq, 1'b0, "holding full");
    wait_on(1'b0);
    repeat (40) @(posedge ref_clk);
    chk(block_irq, 1'b1, "empty irq");
    wr(OFS_FUNC, 32'h1D);
    repeat (2) @(posedge ref_clk);
    chk(block_irq, 1'b1, "complete irq");
    rd(OFS_CTRL, 32'h18, 32'h18, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk(block_irq, 1'b0, "complete cleared");
    rd(OFS_CTRL, 32'h08, 32'h18, 1'b0);
    wr(OFS_FUNC, 32'h0D);
    repeat (2) @(posedge ref_clk);
    chk(block_irq, 1'b1, "empty kept");
    listen = 1'b0;
    par_en = 1'b0;
    wr(OFS_FUNC, 32'h05);
    wr(OFS_CTRL, 32'h81);
    u_remote.send(seed[23:16], 1'b0);
    wait_on(1'b1);
    rd(OFS_CTRL, 32'h08, 32'h08, 1'b0);
    rd(OFS_CTRL, 32'h08, 32'h08, 1'b0);
    rd(OFS_RXDATA, {24'h0, seed[23:16]}, 32'hFF, 1'b0);
    rd(OFS_CTRL, 32'h00, 32'h08, 1'b0);
    u_remote.send(seed[31:24], 1'b1);
    repeat (800) @(posedge ref_clk);
    rd(OFS_CTRL, 32'h20, 32'h20, 1'b0);
    rd(OFS_CTRL, 32'h00, 32'h20, 1'b0);
    repeat (4) @(posedge ref_clk);
    end_of_test();
  end
endmodule : tb

// [sim/utxro_remote.sv]
// remote serial party: frame decoder on the line, frame sender on demand
`timescale 1ns/1ps
module utxro_remote (
  input wire logic ref_clk,
  input wire logic line_in,
  input wire logic par_en,
  output logic line_out,
  output logic [9:0] got,
  output logic got_valid
);
  // one bit is eight baud ticks of eight clocks each
  localparam int BIT = 64;
  initial begin
    line_out = 1'b1;
  end
  // start, eight data lsb first, parity when par_en, stop
  initial begin
    got_valid = 1'b0;
    got = 10'h000;
    forever begin
      @(posedge ref_clk);
      got_valid <= 1'b0;
      if (line_in === 1'b0) begin
        repeat (BIT / 2) @(posedge ref_clk);
        for (int i = 0; i < 10; i++) begin
          if (i != 8 || par_en) begin
            repeat (BIT) @(posedge ref_clk);
            got[i] <= line_in;
          end else begin
            got[8] <= 1'b0;
          end
        end
        got_valid <= 1'b1;
      end
    end
  end
  // bit time of eight baud ticks
  task automatic send(input logic [7:0] b, input logic bad_stop);
    line_out <= 1'b0;
    repeat (BIT) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      line_out <= b[i];
      repeat (BIT) @(posedge ref_clk);
    end
    // low stop only when asked for
    line_out <= ~bad_stop;
    repeat (BIT) @(posedge ref_clk);
    line_out <= 1'b1;
  endtask : send
endmodule : utxro_remote
